// *** hdl/uaf_pkg.sv ***
// constants, field positions and carrier types for the serial port with address filter
// assumes a single 250 MHz system clock standing in for the oscillator
// Functional notes
// R1 - mode 3 uses the 11-bit frame, rate is timer-1 overflow times 2^doubler/32
// R2 - any write to the serial buffer starts a transmission in every mode
// R3 - mode 0 reception starts whenever receive-done is 0 and receive enable is 1
// R4 - modes 1-3 with receive enable start a frame on a falling receive line
// R5 - two mode-select bits pick mode 0, 1, 2 or 3
// R6 - invalid stop bit sets frame error; only a software write clears it
// R7 - control bit 7 is frame error when frame-error-select is 1, else mode bit
// R8 - modes 2/3 with filter: receive-done only if ninth bit 1 and address matches
// R9 - mode 1 with filter: receive-done only if stop bit valid and address matches
// R10 - receive enable resets to 0 and blocks reception until software sets it
// R11 - modes 2/3 transmit the tx ninth bit control as ninth data bit
// R12 - modes 2/3 store the received ninth bit in the rx ninth bit position
// R13 - hardware sets transmit-done when a frame has been sent
// R14 - hardware sets receive-done when a frame is received, subject to the filter
// R15 - compared byte takes slave address bits where mask is 1, others don't-care
// R16 - address filtering acts in modes 1, 2, 3 and never in mode 0
// R17 - slave address and slave address mask are software readable and writable
// R18 - buffer address: writes load transmitter, reads return receive register
// R19 - mode 0 shifts 8 bits lsb first with shift clock, osc/12 or osc/2
// R20 - mode 1 frame is start 0, 8 data, stop 1; stop bit stored as rx ninth bit
// R21 - mode 2 rate is osc/64, or osc/32 with the baud doubler set
// R22 - async receiver oversamples 16x, majority of centre samples, checks start bit
// R23 - hardware never clears done flags; pending receive-done blocks mode 0 receive
// R24 - broadcast address is slave address OR mask, zero bits don't-care
package uaf_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_BUF   = 8'h04;
    localparam logic [7:0] ADDR_SLAVE_ADDRESS = 8'h08;
    localparam logic [7:0] ADDR_SLAVE_ADDRESS_MASK = 8'h0C;
    localparam logic [7:0] ADDR_PWR   = 8'h10;
    localparam logic [7:0] ADDR_AUX   = 8'h14;

    // serial_control fields
    localparam int CTL_MODE_HI = 7;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_FILT    = 5;
    localparam int CTL_REN     = 4;
    localparam int CTL_TB8     = 3;
    localparam int CTL_RB8     = 2;
    localparam int CTL_TI      = 1;
    localparam int CTL_RI      = 0;
    // power_control_reg and auxiliary_control_reg fields
    localparam int PWR_DOUBLER = 7;
    localparam int PWR_FES     = 6;
    localparam int AUX_M0SPEED = 5;

    localparam logic [7:0] REG_RESET = 8'h00;

    // mode 0 bit period in clocks and last bit index of the byte
    localparam logic [3:0] M0_PERIOD_SLOW = 4'hC;
    localparam logic [3:0] M0_PERIOD_FAST = 4'h2;
    localparam logic [3:0] M0_BIT_LAST    = 4'h7;
    // mode 2 oversample tick divider: osc/64 bit = osc/4 tick, osc/32 bit = osc/2 tick
    localparam logic [1:0] M2_TICK_LAST_SLOW = 2'h3;
    localparam logic [1:0] M2_TICK_LAST_FAST = 2'h1;
    // 16x oversampling and centre sample points
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] SAMPLE_A = 4'h7;
    localparam logic [3:0] SAMPLE_B = 4'h8;
    localparam logic [3:0] SAMPLE_C = 4'h9;
    // last bit index of each frame and data length, named by length in bits
    localparam logic [3:0] FRAME_LAST_10 = 4'h9;
    localparam logic [3:0] FRAME_LAST_11 = 4'hA;
    localparam logic [3:0] DATA_LAST_8   = 4'h7;
    localparam logic [3:0] DATA_LAST_9   = 4'h8;

    typedef enum logic [1:0] {
        UAF_MODE0 = 2'b00,
        UAF_MODE1 = 2'b01,
        UAF_MODE2 = 2'b10,
        UAF_MODE3 = 2'b11
    } uaf_mode_e;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } uaf_rx_state_e;

    // captured ahb address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } uaf_bus_req_s;

endpackage : uaf_pkg

// *** hdl/uaf_serial_port.sv ***
// serial port with frame error detection and automatic address recognition
// assumes an ahb-lite master on the register side and timer-1 overflow as a one-clock pulse
`timescale 1ns/1ps
module uaf_serial_port (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        timer1_overflow,
    input  wire logic        rxd_in,
    output logic             rxd_out,
    output logic             rxd_oe_n,
    output logic             txd_out
);
    import uaf_pkg::*;

    uaf_bus_req_s  dphase;
    uaf_rx_state_e rx_state;
    uaf_mode_e     mode;
    logic          mode_hi, mode_lo, filt_en, rx_en, tb8, rb8, ti, ri, fe;
    logic          doubler, fes, m0speed;
    logic [7:0]    slave_address, slave_address_mask, rx_buf;
    logic [7:0]    wbyte, rd_mux, ctrl_view;
    logic          wr_ctrl, wr_buf, wr_slave_address, wr_slave_address_mask, wr_pwr, wr_aux;
    logic          set_ti, set_ri, set_fe, set_rb8, rb8_val;
    logic [7:0]    rx_load;
    // oversample tick
    logic [1:0]    m2_cnt;
    logic [1:0]    m2_last;
    logic          t1_half, tick16;
    // async transmitter
    logic          tx_busy;
    logic [10:0]   tx_shift;
    logic [3:0]    tx_tick, tx_bit, tx_last;
    logic          tx_done_async;
    // mode 0 engine
    logic          m0_busy, m0_tx;
    logic [3:0]    m0_cnt, m0_bits, m0_period, m0_half;
    logic [7:0]    m0_shift;
    logic          m0_end, m0_done, start_m0_tx, start_m0_rx;
    // async receiver
    logic          rx_prev, bit_val, stop_ok, rx_fin, ninth, match, accept;
    logic [3:0]    rx_tick, rx_bit, rx_dlast;
    logic [1:0]    votes;
    logic [8:0]    rx_shift;
    logic [7:0]    rx_byte, bcast;

    assign mode  = uaf_mode_e'({mode_hi, mode_lo}); // R5
    assign wbyte = hwdata[7:0];

    // ahb-lite: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // address phase capture; the master idles during data phases, so no overlap hazard
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dphase <= '0;
        end else if (hready) begin
            dphase.valid <= hsel & htrans[1] & (haddr[31:8] == 24'h000000);
            dphase.write <= hwrite;
            dphase.addr  <= haddr[7:0];
        end
    end

    assign wr_ctrl  = dphase.valid & dphase.write & (dphase.addr == ADDR_CTRL);
    assign wr_buf   = dphase.valid & dphase.write & (dphase.addr == ADDR_BUF);
    assign wr_slave_address = dphase.valid & dphase.write & (dphase.addr == ADDR_SLAVE_ADDRESS);
    assign wr_slave_address_mask = dphase.valid & dphase.write & (dphase.addr == ADDR_SLAVE_ADDRESS_MASK);
    assign wr_pwr   = dphase.valid & dphase.write & (dphase.addr == ADDR_PWR);
    assign wr_aux   = dphase.valid & dphase.write & (dphase.addr == ADDR_AUX);

    // bit 7 shows the frame error flag or the high mode bit
    assign ctrl_view = {(fes ? fe : mode_hi), mode_lo, filt_en, rx_en, tb8, rb8, ti, ri}; // R7

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_mux = 8'h00;
        case (haddr[7:0])
            ADDR_CTRL:  rd_mux = ctrl_view;
            ADDR_BUF:   rd_mux = rx_buf;                          // R18
            ADDR_SLAVE_ADDRESS: rd_mux = slave_address;                           // R17
            ADDR_SLAVE_ADDRESS_MASK: rd_mux = slave_address_mask;                           // R17
            ADDR_PWR:   rd_mux = {doubler, fes, 6'h00};
            ADDR_AUX:   rd_mux = {2'h0, m0speed, 5'h00};
            default:    rd_mux = 8'h00;
        endcase
        if (haddr[31:8] != 24'h000000) begin
            rd_mux = 8'h00;
        end
    end

    // read data latched at the address phase, shown in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= {24'h000000, rd_mux};
        end
    end

    // serial_control: hardware set wins over a software clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_hi <= REG_RESET[CTL_MODE_HI];
            mode_lo <= REG_RESET[CTL_MODE_LO];
            filt_en <= REG_RESET[CTL_FILT];
            rx_en   <= REG_RESET[CTL_REN];                        // R10
            tb8     <= REG_RESET[CTL_TB8];
            rb8     <= REG_RESET[CTL_RB8];
            ti      <= REG_RESET[CTL_TI];
            ri      <= REG_RESET[CTL_RI];
            fe      <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                if (!fes) begin
                    mode_hi <= wbyte[CTL_MODE_HI];                // R7
                end
                mode_lo <= wbyte[CTL_MODE_LO];
                filt_en <= wbyte[CTL_FILT];
                rx_en   <= wbyte[CTL_REN];                        // R10
                tb8     <= wbyte[CTL_TB8];
            end
            rb8 <= set_rb8 ? rb8_val : (wr_ctrl ? wbyte[CTL_RB8] : rb8); // R12
            ti  <= (wr_ctrl ? wbyte[CTL_TI] : ti) | set_ti;       // R13 R23
            ri  <= (wr_ctrl ? wbyte[CTL_RI] : ri) | set_ri;       // R14 R23
            fe  <= ((wr_ctrl && fes) ? wbyte[CTL_MODE_HI] : fe) | set_fe; // R6
        end
    end

    // address filter, power and auxiliary registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slave_address   <= REG_RESET;
            slave_address_mask   <= REG_RESET;
            doubler <= REG_RESET[PWR_DOUBLER];
            fes     <= REG_RESET[PWR_FES];
            m0speed <= REG_RESET[AUX_M0SPEED];
        end else begin
            if (wr_slave_address) begin
                slave_address <= wbyte;                                   // R17
            end
            if (wr_slave_address_mask) begin
                slave_address_mask <= wbyte;                                   // R17
            end
            if (wr_pwr) begin
                doubler <= wbyte[PWR_DOUBLER];
                fes     <= wbyte[PWR_FES];
            end
            if (wr_aux) begin
                m0speed <= wbyte[AUX_M0SPEED];
            end
        end
    end

    // 16x tick: mode 2 from the clock, modes 1/3 from timer-1 overflow halved unless doubled
    assign m2_last = doubler ? M2_TICK_LAST_FAST : M2_TICK_LAST_SLOW; // R21
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            m2_cnt  <= 2'h0;
            t1_half <= 1'b0;
        end else begin
            m2_cnt <= (m2_cnt >= m2_last) ? 2'h0 : m2_cnt + 2'h1;
            if (timer1_overflow) begin
                t1_half <= ~t1_half;
            end
        end
    end
    assign tick16 = (mode == UAF_MODE2) ? (m2_cnt >= m2_last)       // R21
                                        : (timer1_overflow & (doubler | t1_half)); // R1

    // async transmitter; a buffer write restarts it even mid-frame
    assign tx_last = (mode == UAF_MODE1) ? FRAME_LAST_10 : FRAME_LAST_11; // R20 R1
    assign tx_done_async = tx_busy & tick16 & (tx_tick == OVS_LAST) & (tx_bit == tx_last);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_busy  <= 1'b0;
            tx_shift <= 11'h7FF;
            tx_tick  <= 4'h0;
            tx_bit   <= 4'h0;
        end else if (wr_buf && mode != UAF_MODE0) begin
            tx_busy  <= 1'b1;                                     // R2 R18
            tx_shift <= {1'b1, ((mode == UAF_MODE1) ? 1'b1 : tb8), wbyte, 1'b0}; // R11 R20
            tx_tick  <= 4'h0;
            tx_bit   <= 4'h0;
        end else if (tx_busy && tick16) begin
            tx_tick <= tx_tick + 4'h1;
            if (tx_tick == OVS_LAST) begin
                tx_shift <= {1'b1, tx_shift[10:1]};
                tx_bit   <= tx_bit + 4'h1;
                if (tx_bit == tx_last) begin
                    tx_busy <= 1'b0;
                end
            end
        end
    end

    // mode 0 shift engine: clock low in first half of a bit, data sampled before the rise
    assign m0_period   = m0speed ? M0_PERIOD_FAST : M0_PERIOD_SLOW; // R19
    assign m0_half     = {1'b0, m0_period[3:1]};
    assign m0_end      = m0_busy & (m0_cnt == m0_period - 4'h1);
    assign m0_done     = m0_end & (m0_bits == M0_BIT_LAST);
    assign start_m0_tx = wr_buf & (mode == UAF_MODE0);            // R2
    assign start_m0_rx = (mode == UAF_MODE0) & ~m0_busy & rx_en & ~ri & ~wr_buf; // R3 R23
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            m0_busy  <= 1'b0;
            m0_tx    <= 1'b0;
            m0_cnt   <= 4'h0;
            m0_bits  <= 4'h0;
            m0_shift <= 8'h00;
        end else if (start_m0_tx) begin
            m0_busy  <= 1'b1;
            m0_tx    <= 1'b1;
            m0_cnt   <= 4'h0;
            m0_bits  <= 4'h0;
            m0_shift <= wbyte;
        end else if (start_m0_rx) begin
            m0_busy <= 1'b1;
            m0_tx   <= 1'b0;
            m0_cnt  <= 4'h0;
            m0_bits <= 4'h0;
        end else if (m0_busy) begin
            if (!m0_tx && m0_cnt == m0_half - 4'h1) begin
                m0_shift <= {rxd_in, m0_shift[7:1]};              // R19
            end
            if (m0_end) begin
                m0_cnt  <= 4'h0;
                m0_bits <= m0_bits + 4'h1;
                if (m0_tx) begin
                    m0_shift <= {1'b0, m0_shift[7:1]};            // R19
                end
                if (m0_done) begin
                    m0_busy <= 1'b0;
                end
            end else begin
                m0_cnt <= m0_cnt + 4'h1;
            end
        end
    end

    // pins: mode 0 borrows the receive pin for data and the transmit pin for the shift clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            txd_out  <= 1'b1;
            rxd_out  <= 1'b1;
            rxd_oe_n <= 1'b1;
        end else begin
            txd_out  <= (mode == UAF_MODE0) ? ~(m0_busy & (m0_cnt < m0_half) & ~m0_end & ~start_m0_tx
                                               & ~start_m0_rx | (m0_busy & m0_cnt < m0_half & ~m0_end))
                                            : (tx_busy ? tx_shift[0] : 1'b1);
            rxd_out  <= m0_shift[0];
            rxd_oe_n <= ~(m0_busy & m0_tx);                       // R19
        end
    end

    // async receiver: falling edge arms it, majority of samples 7-9 decides each bit
    assign rx_dlast = (mode == UAF_MODE1) ? DATA_LAST_8 : DATA_LAST_9; // R20 R12
    assign bit_val  = votes[1];                                   // R22
    assign rx_fin   = (rx_state == RX_STOP) & tick16 & (rx_tick == OVS_LAST);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_state <= RX_IDLE;
            rx_prev  <= 1'b1;
            rx_tick  <= 4'h0;
            rx_bit   <= 4'h0;
            votes    <= 2'h0;
            rx_shift <= 9'h000;
        end else begin
            rx_prev <= rxd_in;
            case (rx_state)
                RX_IDLE: begin
                    if (mode != UAF_MODE0 && rx_en && rx_prev && !rxd_in) begin // R4 R10
                        rx_state <= RX_START;
                        rx_tick  <= 4'h0;
                        votes    <= 2'h0;
                    end
                end
                RX_START, RX_DATA, RX_STOP: begin
                    if (tick16) begin
                        rx_tick <= rx_tick + 4'h1;
                        if ((rx_tick == SAMPLE_A || rx_tick == SAMPLE_B || rx_tick == SAMPLE_C) && rxd_in) begin
                            votes <= votes + 2'h1;                // R22
                        end
                        if (rx_tick == OVS_LAST) begin
                            votes <= 2'h0;
                            if (rx_state == RX_START) begin
                                rx_state <= bit_val ? RX_IDLE : RX_DATA; // R22
                                rx_bit   <= 4'h0;
                            end else if (rx_state == RX_DATA) begin
                                rx_shift <= {bit_val, rx_shift[8:1]};
                                rx_bit   <= rx_bit + 4'h1;
                                if (rx_bit == rx_dlast) begin
                                    rx_state <= RX_STOP;
                                end
                            end else begin
                                rx_state <= RX_IDLE;
                            end
                        end
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // frame completion and address recognition
    assign stop_ok = bit_val;
    assign rx_byte = (mode == UAF_MODE1) ? rx_shift[8:1] : rx_shift[7:0];
    assign ninth   = (mode == UAF_MODE1) ? stop_ok : rx_shift[8]; // R20 R12
    assign bcast   = slave_address | slave_address_mask;                               // R24
    assign match   = (((rx_byte ^ slave_address) & slave_address_mask) == 8'h00)        // R15
                   | ((rx_byte & bcast) == bcast);                // R24
    always_comb begin
        accept = 1'b1;
        if (filt_en) begin                                        // R16
            accept = (mode == UAF_MODE1) ? (stop_ok & match)      // R9
                                         : (ninth & match);       // R8
        end
    end

    // event merge from both engines
    assign set_ti  = tx_done_async | (m0_done & m0_tx);           // R13
    assign set_ri  = (rx_fin & accept) | (m0_done & ~m0_tx);      // R14
    assign set_fe  = rx_fin & ~stop_ok;                           // R6
    assign set_rb8 = rx_fin & accept;
    assign rb8_val = ninth;                                       // R12 R20
    assign rx_load = rx_fin ? rx_byte : m0_shift;

    // receive register, separate from the transmit path
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_buf <= REG_RESET;
        end else if (set_ri) begin
            rx_buf <= rx_load;                                    // R18
        end
    end

endmodule : uaf_serial_port

// *** tb/uaf_serial_port_properties.sv ***
// checker for the register side and transmit start of the serial port
// assumes a zero-wait ahb-lite slave and one clock domain
`timescale 1ns/1ps
module uaf_serial_port_properties
    import uaf_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        txd_out
);
    logic       dv;
    logic       dw;
    logic [7:0] da;
    logic [7:0] sa;
    logic [7:0] sm;
    logic [3:0] sc;
    logic [2:0] seen;
    wire        wr = dv && dw;
    wire        rd = dv && !dw;
    // address phase carried into the data phase
    always_ff @(posedge hclk) begin
        dw <= hwrite;
        da <= haddr[7:0];
    end
    // shadows; flags seen high stay expected until software rewrites control or power
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {dv, sa, sm, sc, seen} <= '0;
        end else begin
            dv <= hsel && htrans[1] && hready;
            if (wr && da == ADDR_SLAVE_ADDRESS) sa <= hwdata[7:0];
            if (wr && da == ADDR_SLAVE_ADDRESS_MASK) sm <= hwdata[7:0];
            if (wr && da == ADDR_CTRL) sc <= hwdata[6:3];
            if (wr && (da == ADDR_CTRL || da == ADDR_PWR)) seen <= '0;
            else if (rd && da == ADDR_CTRL) seen <= seen | {hrdata[7], hrdata[1:0]};
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_okay; hreadyout && !hresp; endproperty
    a_okay: assert property (p_okay) else $error("bus answer not zero-wait okay");
    property p_slave_address; rd && da == ADDR_SLAVE_ADDRESS |-> hrdata[7:0] == sa; endproperty
    a_slave_address: assert property (p_slave_address) else $error("slave address readback wrong");
    property p_mask; rd && da == ADDR_SLAVE_ADDRESS_MASK |-> hrdata[7:0] == sm; endproperty
    a_mask: assert property (p_mask) else $error("address mask readback wrong");
    property p_ctl; rd && da == ADDR_CTRL |-> hrdata[6:3] == sc; endproperty
    a_ctl: assert property (p_ctl) else $error("control bits readback wrong");
    property p_sticky; rd && da == ADDR_CTRL |-> ({hrdata[7], hrdata[1:0]} & seen) == seen; endproperty
    a_sticky: assert property (p_sticky) else $error("flag cleared without a write");
    property p_unmap; rd && da > ADDR_AUX |-> hrdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_txstart; wr && da == ADDR_BUF |-> ##[1:40] !txd_out; endproperty
    a_txstart: assert property (p_txstart) else $error("buffer write did not start a frame");
    property p_reset; $rose(hresetn) |-> txd_out && hrdata == 32'h0; endproperty
    a_reset: assert property (p_reset) else $error("outputs not idle after reset");
endmodule : uaf_serial_port_properties
bind uaf_serial_port uaf_serial_port_properties uaf_serial_port_properties_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .txd_out
);

// *** tb/uaf_remote_node.sv ***
// remote asynchronous node: drives the receive line and samples the transmit line
// assumes doubled rates, 32 clocks a bit; its line idles high like a pulled-up wire
`timescale 1ns/1ps
module uaf_remote_node #(
    parameter int BIT = 32
) (
    input  wire logic hclk,
    output logic      line,
    input  wire logic txd
);
    initial line = 1'b1;
    // frame bits lsb first from the start bit; the line returns to idle after
    task automatic send(input logic [10:0] f);
        for (int i = 0; i < 11; i++) begin
            line <= f[i];
            repeat (BIT) @(posedge hclk);
        end
        line <= 1'b1;
    endtask : send
    // centre sampling, so a tick of start jitter does not matter
    task automatic capture(output logic [9:0] got);
        while (txd !== 1'b0) @(posedge hclk);
        repeat (BIT / 2) @(posedge hclk);
        for (int i = 0; i < 10; i++) begin
            repeat (BIT) @(posedge hclk);
            got[i] = txd;
        end
    endtask : capture
endmodule : uaf_remote_node

// *** tb/uaf_serial_port_bench.sv ***
// self-checking bench: ahb-lite register tasks plus a remote serial node
// assumes zero-wait answers; timer-1 overflows every second clock
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; $display("Error %s expected %h seen %h", nm, e, g); end end
module uaf_serial_port_bench;
    import uaf_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        tmr = 1'b0;
    logic        hreadyout, hresp, rxd_out, rxd_oe_n, txd_out, line;
    logic [31:0] hrdata, r;
    logic [9:0]  got;
    logic [7:0]  c;
    logic [9:0]  cs [6] = '{10'h3C2, 10'h1C4, 10'h0C0, 10'h3FF, 10'h3C2, 10'h0C2};
    int          err_count = 0;
    int          n_tests = 0;
    wire         rxd_wire = rxd_oe_n ? line : rxd_out;
    uaf_serial_port uaf_serial_port_i (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .timer1_overflow(tmr), .rxd_in(rxd_wire),
        .rxd_out, .rxd_oe_n, .txd_out);
    uaf_remote_node remote_i (.hclk, .line, .txd(txd_out));
    initial forever #2 hclk = ~hclk;
    // overflow pulse every other clock gives 32-clock bits with the doubler set
    always @(posedge hclk) tmr <= ~tmr;
    // one single word transfer; read data taken at the data-phase edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge hclk);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : xfer
    task automatic chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
        xfer(1'b0, a, 8'h00);
        `CHK(nm, e, r[7:0] & m)
    endtask : chk
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    // hang guard, well beyond the eleven async frames and three shift bytes of the run
    initial begin
        repeat (40000) @(posedge hclk);
        err_count++;
        close_out();
    end
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        chk(ADDR_CTRL, 8'hFF, 8'h00, "control reset");
        xfer(1'b1, ADDR_SLAVE_ADDRESS, 8'hC0);
        xfer(1'b1, ADDR_SLAVE_ADDRESS_MASK, 8'hFD);
        xfer(1'b1, 8'h40, 8'h55);
        chk(ADDR_SLAVE_ADDRESS, 8'hFF, 8'hC0, "slave address");
        chk(ADDR_SLAVE_ADDRESS_MASK, 8'hFF, 8'hFD, "address mask");
        chk(8'h40, 8'hFF, 8'h00, "unmapped");
        xfer(1'b1, ADDR_PWR, 8'h80);
        // one frame out in modes 1, 2, 3; ninth bit set in mode 2 only
        for (int i = 1; i < 4; i++) begin
            c = {2'(i), 2'b00, i == 2, 3'b000};
            xfer(1'b1, ADDR_CTRL, c);
            fork
                remote_i.capture(got);
                xfer(1'b1, ADDR_BUF, 8'hA5);
            join
            `CHK("tx frame", {1'b1, i != 3, 8'hA5}, got)
            repeat (24) @(posedge hclk);
            chk(ADDR_CTRL, 8'h02, 8'h02, "tx done");
        end
        xfer(1'b1, ADDR_CTRL, 8'hD0);
        remote_i.send({2'b10, 8'h3C, 1'b0});
        chk(ADDR_BUF, 8'hFF, 8'h3C, "rx data");
        chk(ADDR_CTRL, 8'hFF, 8'hD1, "rx flags");
        // filtered reception: four frames in mode 3, two in mode 1
        for (int k = 0; k < 6; k++) begin
            xfer(1'b1, ADDR_CTRL, k < 4 ? 8'hF0 : 8'h70);
            remote_i.send({1'b1, cs[k][8:0], 1'b0});
            chk(ADDR_CTRL, 8'h01, {7'h0, cs[k][9]}, "filtered rx done");
        end
        // back to mode 3 so that mode_hi is 1 while frame-error-select owns bit 7
        xfer(1'b1, ADDR_CTRL, 8'hF0);
        xfer(1'b1, ADDR_PWR, 8'hC0);
        chk(ADDR_CTRL, 8'h80, 8'h80, "frame error");
        remote_i.send({2'b11, 8'hC2, 1'b0});
        chk(ADDR_CTRL, 8'h80, 8'h80, "frame error kept");
        xfer(1'b1, ADDR_CTRL, 8'h70);
        chk(ADDR_CTRL, 8'h80, 8'h00, "frame error cleared");
        xfer(1'b1, ADDR_PWR, 8'h00);
        chk(ADDR_CTRL, 8'hC0, 8'hC0, "mode bits kept");
        // shift register mode: out with the data pin driven, then in with enable set
        xfer(1'b1, ADDR_CTRL, 8'h00);
        xfer(1'b1, ADDR_BUF, 8'h5A);
        // sample the data pin in the middle of each 12-clock bit, lsb first
        for (int b = 0; b < 8; b++) begin
            repeat (6) @(posedge hclk);
            c[b] = rxd_out;
            `CHK("data pin drive", 1'b0, rxd_oe_n)
            repeat (6) @(posedge hclk);
        end
        `CHK("shift tx data", 8'h5A, c)
        repeat (24) @(posedge hclk);
        chk(ADDR_CTRL, 8'h02, 8'h02, "shift tx done");
        xfer(1'b1, ADDR_CTRL, 8'h10);
        repeat (120) @(posedge hclk);
        chk(ADDR_BUF, 8'hFF, 8'hFF, "shift rx data");
        chk(ADDR_CTRL, 8'h01, 8'h01, "shift rx done");
        // fast shift rate: eight 2-clock bits finish long before a slow byte would
        xfer(1'b1, ADDR_AUX, 8'h20);
        xfer(1'b1, ADDR_BUF, 8'h5A);
        repeat (20) @(posedge hclk);
        chk(ADDR_CTRL, 8'h02, 8'h02, "fast shift done");
        close_out();
    end
endmodule : uaf_serial_port_bench
